/* File: rtl/e1fm_pkg.sv */
package e1fm_pkg;

  localparam int unsigned E1FM_AW = 5;
  localparam int unsigned E1FM_DW = 8;

  // register offsets on the parallel port
  localparam logic [4:0] OFS_FRAMER_MODE_SELECT     = 5'h10;
  localparam logic [4:0] OFS_TRANSMIT_ALARM_CONTROL = 5'h11;
  localparam logic [4:0] OFS_LINK_CONTROLLER_SELECT = 5'h12;

  // reset values
  localparam logic [7:0] RST_FRAMER_MODE_SELECT     = 8'h00;
  localparam logic [7:0] RST_TRANSMIT_ALARM_CONTROL = 8'h10;
  localparam logic [7:0] RST_LINK_CONTROLLER_SELECT = 8'h02;

  // writable bits; unused bits read as zero except in framer_mode_select, where all eight bits are writable
  localparam logic [7:0] MSK_FRAMER_MODE_SELECT     = 8'hff;
  localparam logic [7:0] MSK_TRANSMIT_ALARM_CONTROL = 8'h70;
  localparam logic [7:0] MSK_LINK_CONTROLLER_SELECT = 8'h3f;

  // framer_mode_select fields
  localparam int unsigned BIT_AUTO_INTERWORK_OFF         = 5;
  localparam int unsigned BIT_CRC4_SYNC_DISABLE          = 2;
  localparam int unsigned BIT_BASIC_REFRAME_REQUEST      = 1;
  localparam int unsigned BIT_MULTIFRAME_REFRAME_REQUEST = 0;

  // transmit_alarm_control fields
  localparam int unsigned BIT_EBIT_LOSS_VALUE    = 6;
  localparam int unsigned BIT_SLOT16_ALARM_FORCE = 5;
  localparam int unsigned BIT_TX_ALL_ONES_N      = 4;

  // link_controller_select fields
  localparam int unsigned BIT_SA_LINK_CONTROLLER     = 5;
  localparam int unsigned BIT_SLOT16_LINK_CONTROLLER = 4;
  localparam int unsigned BIT_RX_TRANSPARENT         = 3;
  localparam int unsigned BIT_TX_TRANSPARENT         = 2;
  localparam int unsigned BIT_INTL_USE_BIT_NFA       = 1;
  localparam int unsigned BIT_INTL_USE_BIT_FA        = 0;

  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [4:0] addr;
    logic [7:0] din;
  } e1fm_bus_t;

  localparam e1fm_bus_t E1FM_BUS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
                                          addr: 5'h00, din: 8'h00};

  typedef struct packed {
    logic crc4_enable;
    logic auto_interwork_on;
    logic intl_bits_send;
    logic intl_bit_fa;
    logic intl_bit_nfa;
    logic ebit_from_crc;
    logic ebit_value;
    logic slot16_all_ones;
    logic unframed_all_ones;
    logic sa_link_on;
    logic slot16_link_on;
    logic rx_transparent;
    logic tx_transparent;
    logic tx_ccs_mode;
  } e1fm_ctrl_t;

endpackage

/* File: rtl/e1fm_ctrl.sv */
// Function
// - crc4_sync_disable low runs CRC-4 sync and overrides programmed international bits.
// - CRC-4 off and interworking off: send programmed international bits in slot 0.
// - host holds basic reframe a frame; device starts basic search on its fall.
// - host holds multiframe reframe a frame; device starts multiframe search on fall.
// - E-bit select zero with CRC-4 sync: E-bits carry received CRC-4 results.
// - CRC-4 sync lost with E-bit select zero: transmit E-bits are zero.
// - CRC-4 sync lost with E-bit select one: transmit E-bits are one.
// - slot-16 alarm bit one sends all ones in slot 16, else normal.
// - tx_all_ones_n low transmits unframed all ones on the line pair.
// - Sa link controller select connects it to Sa bits, else masks interrupts.
// - slot-16 link controller select connects it in CCS mode, else masks interrupts.
// - rx_transparent disables receive framing, data passes with arbitrary alignment.
// - tx_transparent sends serial input unframed; zero means termination mode.
// - CRC-4 off sends bit 1 in non-alignment frames; ignored with CRC-4.
// - auto_interwork_off zero activates automatic CRC interworking; one deactivates it.
// - tx_common_signalling one selects CCS on transmit, else CAS.
`timescale 1ns/100ps
module e1fm_ctrl
  import e1fm_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // parallel host port pins
  input  wire logic                 cs_n,
  input  wire logic                 rd_n,
  input  wire logic                 wr_n,
  input  wire logic [E1FM_AW-1:0]   addr,
  input  wire logic [E1FM_DW-1:0]   data_in,
  output logic      [E1FM_DW-1:0]   data_out,
  output logic                      data_oe,
  // framer status, same clock
  input  wire logic                 frame_start,
  input  wire logic                 crc4_sync_achieved,
  input  wire logic                 tx_common_signalling,
  input  wire logic                 sa_link_irq,
  input  wire logic                 slot16_link_irq,
  // framer controls
  output e1fm_pkg::e1fm_ctrl_t      ctrl,
  output logic                      basic_reframe_start,
  output logic                      multiframe_reframe_start,
  output logic                      sa_link_irq_out,
  output logic                      slot16_link_irq_out
);
  import e1fm_pkg::*;

  typedef struct packed {
    e1fm_bus_t  s1;
    e1fm_bus_t  s2;
    e1fm_bus_t  s3;
    logic [7:0] mode;
    logic [7:0] alarm;
    logic [7:0] link;
    logic [7:0] mode_app;
    logic [7:0] alarm_app;
    logic [7:0] link_app;
    logic       ccs_app;
    e1fm_ctrl_t ctrl;
    logic       basic_rf;
    logic       mf_rf;
    logic       sa_irq;
    logic       s16_irq;
    logic [7:0] dout;
    logic       doe;
  } e1fm_state_t;

  e1fm_state_t st;
  e1fm_state_t next_st;

  always_comb begin
    logic wr_done;
    logic rd_act;
    wr_done = 1'b0;
    rd_act  = 1'b0;
    next_st = st;
    // pins cross into clk through two flops; s3 feeds edge detection and the write address and data
    next_st.s1 = '{cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, addr: addr, din: data_in};
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // write taken on the rising edge of wr_n, with address and data still held
    wr_done = st.s2.wr_n && !st.s3.wr_n && !st.s3.cs_n;
    if (wr_done) begin
      unique case (st.s3.addr)
        OFS_FRAMER_MODE_SELECT:
          next_st.mode = st.s3.din & MSK_FRAMER_MODE_SELECT;
        OFS_TRANSMIT_ALARM_CONTROL:
          next_st.alarm = st.s3.din & MSK_TRANSMIT_ALARM_CONTROL;
        OFS_LINK_CONTROLLER_SELECT:
          next_st.link = st.s3.din & MSK_LINK_CONTROLLER_SELECT;
        default: ;
      endcase
    end
    rd_act = !st.s2.cs_n && !st.s2.rd_n;
    next_st.doe = rd_act;
    if (rd_act) begin
      unique case (st.s2.addr)
        OFS_FRAMER_MODE_SELECT:     next_st.dout = st.mode;
        OFS_TRANSMIT_ALARM_CONTROL: next_st.dout = st.alarm;
        OFS_LINK_CONTROLLER_SELECT: next_st.dout = st.link;
        default:                    next_st.dout = 8'h00;
      endcase
    end
    next_st.basic_rf = st.mode[BIT_BASIC_REFRAME_REQUEST]
                       && !next_st.mode[BIT_BASIC_REFRAME_REQUEST];
    next_st.mf_rf = st.mode[BIT_MULTIFRAME_REFRAME_REQUEST]
                    && !next_st.mode[BIT_MULTIFRAME_REFRAME_REQUEST];
    if (frame_start) begin
      next_st.mode_app  = st.mode;
      next_st.alarm_app = st.alarm;
      next_st.link_app  = st.link;
      next_st.ccs_app   = tx_common_signalling;
    end
    next_st.ctrl.crc4_enable = !st.mode_app[BIT_CRC4_SYNC_DISABLE];
    next_st.ctrl.auto_interwork_on = !st.mode_app[BIT_AUTO_INTERWORK_OFF];
    next_st.ctrl.intl_bits_send = st.mode_app[BIT_CRC4_SYNC_DISABLE]
                                  && st.mode_app[BIT_AUTO_INTERWORK_OFF];
    next_st.ctrl.intl_bit_fa = st.link_app[BIT_INTL_USE_BIT_FA];
    next_st.ctrl.intl_bit_nfa = st.mode_app[BIT_CRC4_SYNC_DISABLE]
                                ? st.link_app[BIT_INTL_USE_BIT_NFA] : 1'b1;
    next_st.ctrl.ebit_from_crc = crc4_sync_achieved && !st.alarm_app[BIT_EBIT_LOSS_VALUE];
    next_st.ctrl.ebit_value = st.alarm_app[BIT_EBIT_LOSS_VALUE];
    next_st.ctrl.slot16_all_ones = st.alarm_app[BIT_SLOT16_ALARM_FORCE];
    next_st.ctrl.unframed_all_ones = !st.alarm_app[BIT_TX_ALL_ONES_N];
    next_st.ctrl.sa_link_on = st.link_app[BIT_SA_LINK_CONTROLLER];
    next_st.ctrl.slot16_link_on = st.link_app[BIT_SLOT16_LINK_CONTROLLER] && st.ccs_app;
    next_st.ctrl.rx_transparent = st.link_app[BIT_RX_TRANSPARENT];
    next_st.ctrl.tx_transparent = st.link_app[BIT_TX_TRANSPARENT];
    next_st.ctrl.tx_ccs_mode = st.ccs_app;
    next_st.sa_irq  = sa_link_irq && st.link_app[BIT_SA_LINK_CONTROLLER];
    next_st.s16_irq = slot16_link_irq && st.link_app[BIT_SLOT16_LINK_CONTROLLER];
    if (!reset_n) begin
      next_st           = '0;
      next_st.s1        = E1FM_BUS_IDLE;
      next_st.s2        = E1FM_BUS_IDLE;
      next_st.s3        = E1FM_BUS_IDLE;
      next_st.mode      = RST_FRAMER_MODE_SELECT;
      next_st.alarm     = RST_TRANSMIT_ALARM_CONTROL;
      next_st.link      = RST_LINK_CONTROLLER_SELECT;
      next_st.mode_app  = RST_FRAMER_MODE_SELECT;
      next_st.alarm_app = RST_TRANSMIT_ALARM_CONTROL;
      next_st.link_app  = RST_LINK_CONTROLLER_SELECT;
      next_st.ctrl.crc4_enable       = 1'b1;
      next_st.ctrl.auto_interwork_on = 1'b1;
      next_st.ctrl.intl_bit_nfa      = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  assign data_out                 = st.dout;
  assign data_oe                  = st.doe;
  assign ctrl                     = st.ctrl;
  assign basic_reframe_start      = st.basic_rf;
  assign multiframe_reframe_start = st.mf_rf;
  assign sa_link_irq_out          = st.sa_irq;
  assign slot16_link_irq_out      = st.s16_irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_basic_fall;
    $fell(st.mode[BIT_BASIC_REFRAME_REQUEST]) |-> basic_reframe_start;
  endproperty
  a_basic_fall: assert property (p_basic_fall)
    else $error("basic reframe missed");

  property p_mf_only_on_fall;
    multiframe_reframe_start |-> $fell(st.mode[BIT_MULTIFRAME_REFRAME_REQUEST]);
  endproperty
  a_mf_only_on_fall: assert property (p_mf_only_on_fall)
    else $error("stray mf reframe");

  property p_apply_at_frame;
    ($changed(st.alarm_app) || $changed(st.link_app) || $changed(st.mode_app))
      |-> $past(frame_start);
  endproperty
  a_apply_at_frame: assert property (p_apply_at_frame)
    else $error("control applied mid-frame");

  property p_all_ones;
    !st.alarm_app[BIT_TX_ALL_ONES_N] [*2] |-> ctrl.unframed_all_ones;
  endproperty
  a_all_ones: assert property (p_all_ones)
    else $error("all ones not sent");

  property p_ebit_loss;
    !crc4_sync_achieved ##1 1 |-> !ctrl.ebit_from_crc
      && ctrl.ebit_value == $past(st.alarm_app[BIT_EBIT_LOSS_VALUE]);
  endproperty
  a_ebit_loss: assert property (p_ebit_loss)
    else $error("wrong E-bits on sync loss");

  property p_ebit_crc;
    crc4_sync_achieved && !st.alarm_app[BIT_EBIT_LOSS_VALUE] |=> ctrl.ebit_from_crc;
  endproperty
  a_ebit_crc: assert property (p_ebit_crc)
    else $error("E-bits not from CRC");

  property p_sa_mask;
    sa_link_irq_out |-> $past(st.link_app[BIT_SA_LINK_CONTROLLER]) && $past(sa_link_irq);
  endproperty
  a_sa_mask: assert property (p_sa_mask)
    else $error("masked Sa interrupt passed");

  property p_intl_send;
    ##1 ctrl.intl_bits_send == ($past(st.mode_app[BIT_CRC4_SYNC_DISABLE])
                                && $past(st.mode_app[BIT_AUTO_INTERWORK_OFF]));
  endproperty
  a_intl_send: assert property (p_intl_send)
    else $error("intl bits select wrong");

  property p_crc4_en;
    ##1 ctrl.crc4_enable == !$past(st.mode_app[BIT_CRC4_SYNC_DISABLE]);
  endproperty
  a_crc4_en: assert property (p_crc4_en)
    else $error("crc4 enable wrong");

endmodule // e1fm_ctrl

/* File: test/e1fm_host_model.sv */
`timescale 1ns/100ps
module e1fm_host_model (
  // clock
  input  wire logic                         clk,
  // parallel port pins
  output e1fm_pkg::e1fm_bus_t               bus,
  input  wire logic [e1fm_pkg::E1FM_DW-1:0] data_out,
  input  wire logic                         data_oe
);
  import e1fm_pkg::*;

  initial bus = E1FM_BUS_IDLE;

  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  // deselected pins flip so a stale value never passes
  task automatic release_pins();
    bus.cs_n = 1'b1;
    bus.addr = ~bus.addr;
    bus.din = ~bus.din;
  endtask

  // addr and data held 4 clocks past the wr_n rise
  task automatic write(input logic [4:0] a, input logic [7:0] d);
    bus.cs_n = 1'b0;
    bus.addr = a;
    bus.din = d;
    bus.wr_n = 1'b0;
    tick(5);
    bus.wr_n = 1'b1;
    tick(4);
    release_pins();
    tick(5);
  endtask

  task automatic read(input logic [4:0] a, output logic [7:0] d, output logic oe);
    bus.cs_n = 1'b0;
    bus.addr = a;
    bus.rd_n = 1'b0;
    tick(6);
    d = data_out;
    oe = data_oe;
    bus.rd_n = 1'b1;
    release_pins();
    tick(5);
  endtask
endmodule // e1fm_host_model

/* File: test/e1_framer_mode_tx_alarm_link_control_bench.sv */
`timescale 1ns/100ps
module e1_framer_mode_tx_alarm_link_control_bench;
  import e1fm_pkg::*;
  logic       clk;
  logic       reset_n;
  logic       frame_start;
  logic       sync;
  logic       ccs;
  logic       sa_irq;
  logic       s16_irq;
  e1fm_bus_t  bus;
  logic [7:0] data_out;
  logic       data_oe;
  e1fm_ctrl_t ctrl;
  logic       basic_start;
  logic       mf_start;
  logic       sa_out;
  logic       s16_out;
  logic [7:0] rd;
  logic       oe;
  int         failures = 0;
  int         check_count = 0;
  int         basic_seen = 0;
  int         mf_seen = 0;

  always #2.5 clk = ~clk;

  e1fm_ctrl u_dut (.clk(clk), .reset_n(reset_n), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
    .wr_n(bus.wr_n), .addr(bus.addr), .data_in(bus.din), .data_out(data_out),
    .data_oe(data_oe), .frame_start(frame_start), .crc4_sync_achieved(sync),
    .tx_common_signalling(ccs), .sa_link_irq(sa_irq), .slot16_link_irq(s16_irq),
    .ctrl(ctrl), .basic_reframe_start(basic_start), .multiframe_reframe_start(mf_start),
    .sa_link_irq_out(sa_out), .slot16_link_irq_out(s16_out));
  e1fm_host_model u_host (.clk(clk), .bus(bus), .data_out(data_out), .data_oe(data_oe));

  always @(posedge clk) begin
    if (basic_start === 1'b1) basic_seen++;
    if (mf_start === 1'b1) mf_seen++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic e1fm_ctrl_t model(input logic [7:0] m, a, l, input logic s, c);
    e1fm_ctrl_t e;
    e.crc4_enable = !m[2];
    e.auto_interwork_on = !m[5];
    e.intl_bits_send = m[2] & m[5];
    e.intl_bit_fa = l[0];
    e.intl_bit_nfa = m[2] ? l[1] : 1'b1;
    e.ebit_from_crc = s & !a[6];
    e.ebit_value = a[6];
    e.slot16_all_ones = a[5];
    e.unframed_all_ones = !a[4];
    e.sa_link_on = l[5];
    e.slot16_link_on = l[4] & c;
    e.rx_transparent = l[3];
    e.tx_transparent = l[2];
    e.tx_ccs_mode = c;
    return e;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // applied copy at the strobe, ctrl one edge later
  task automatic frame();
    frame_start = 1'b1;
    u_host.tick(1);
    frame_start = 1'b0;
    u_host.tick(2);
  endtask

  task automatic test_reset();
    u_host.read(OFS_FRAMER_MODE_SELECT, rd, oe);
    check(rd, 8'h00);
    check(oe, 1'b1);
    check(data_oe, 1'b0);
    u_host.read(OFS_TRANSMIT_ALARM_CONTROL, rd, oe);
    check(rd, 8'h10);
    u_host.read(OFS_LINK_CONTROLLER_SELECT, rd, oe);
    check(rd, 8'h02);
    u_host.read(5'h05, rd, oe);
    check(rd, 8'h00);
    check(ctrl, model(8'h00, 8'h10, 8'h02, 1'b0, 1'b0));
    $display("test_reset done");
  endtask

  task automatic test_apply();
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'he4);
    u_host.write(OFS_TRANSMIT_ALARM_CONTROL, 8'hff);
    u_host.write(OFS_LINK_CONTROLLER_SELECT, 8'hff);
    u_host.read(OFS_TRANSMIT_ALARM_CONTROL, rd, oe);
    check(rd, 8'h70);
    u_host.read(OFS_LINK_CONTROLLER_SELECT, rd, oe);
    check(rd, 8'h3f);
    check(ctrl, model(8'h00, 8'h10, 8'h02, 1'b0, 1'b0));
    sync = 1'b1;
    ccs = 1'b1;
    frame();
    check(ctrl, model(8'he4, 8'h70, 8'h3f, 1'b1, 1'b1));
    sync = 1'b0;
    u_host.tick(2);
    check(ctrl, model(8'he4, 8'h70, 8'h3f, 1'b0, 1'b1));
    $display("test_apply done");
  endtask

  task automatic test_clear();
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'h00);
    u_host.write(OFS_TRANSMIT_ALARM_CONTROL, 8'h00);
    u_host.write(OFS_LINK_CONTROLLER_SELECT, 8'h10);
    frame();
    check(ctrl, model(8'h00, 8'h00, 8'h10, 1'b0, 1'b1));
    sync = 1'b1;
    u_host.tick(2);
    check(ctrl, model(8'h00, 8'h00, 8'h10, 1'b1, 1'b1));
    sa_irq = 1'b1;
    s16_irq = 1'b1;
    u_host.tick(2);
    check(sa_out, 1'b0);
    check(s16_out, 1'b1);
    sa_irq = 1'b0;
    s16_irq = 1'b0;
    check(basic_seen + mf_seen, 16'h0000);
    $display("test_clear done");
  endtask

  task automatic test_reframe();
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'h03);
    frame();
    check(basic_seen + mf_seen, 16'h0000);
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'h01);
    check(basic_seen, 16'h0001);
    check(mf_seen, 16'h0000);
    frame();
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'h00);
    check(basic_seen, 16'h0001);
    check(mf_seen, 16'h0001);
    $display("test_reframe done");
  endtask

  // crc off with interworking on: nfa bit sent as written, zero here
  task automatic test_intl();
    ccs = 1'b0;
    u_host.write(OFS_FRAMER_MODE_SELECT, 8'h04);
    u_host.write(OFS_LINK_CONTROLLER_SELECT, 8'h21);
    u_host.write(OFS_TRANSMIT_ALARM_CONTROL, 8'h10);
    frame();
    check(ctrl, model(8'h04, 8'h10, 8'h21, 1'b1, 1'b0));
    sa_irq = 1'b1;
    u_host.tick(2);
    check(sa_out, 1'b1);
    check(s16_out, 1'b0);
    sa_irq = 1'b0;
    $display("test_intl done");
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    frame_start = 1'b0;
    sync = 1'b0;
    ccs = 1'b0;
    sa_irq = 1'b0;
    s16_irq = 1'b0;
    u_host.tick(2);
    reset_n = 1'b1;
    u_host.tick(1);
    test_reset();
    test_apply();
    test_clear();
    test_reframe();
    test_intl();
    report_and_stop();
  end

  // whole sequence needs well under 1000 clocks
  initial begin
    #20000;
    failures++;
    report_and_stop();
  end
endmodule // e1_framer_mode_tx_alarm_link_control_bench
